// file: sim/oms_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module oms_ctrl_model (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic slow_i,
    input wire logic [2:0] ident_i,
    output logic [1:0] ident_o,
    output logic [31:0] word_o,
    output logic [5:0] bits_o
);
    logic act_q;
    logic stb_q;
    logic [2:0] wait_q;
    logic fresh;

    // new bit: frame start or strobe toggle
    assign fresh = ident_i[2] && (!act_q || ident_i[1] != stb_q);
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act_q <= 1'b0;
            stb_q <= 1'b0;
            wait_q <= 3'h0;
            ident_o <= 2'h0;
            word_o <= 32'h0;
            bits_o <= 6'h0;
        end else begin
            act_q <= ident_i[2];
            stb_q <= ident_i[1];
            ident_o[0] <= req_i;
            if (fresh) begin
                word_o <= {word_o[30:0], ident_i[0]};
                bits_o <= act_q ? bits_o + 6'h1 : 6'h1;
                wait_q <= slow_i ? 3'h4 : 3'h1;
                ident_o[1] <= 1'b0;
            end else if (!ident_i[2]) begin
                ident_o[1] <= 1'b0;
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
                ident_o[1] <= wait_q == 3'h1;
            end
        end
    end
endmodule : oms_ctrl_model
`default_nettype wire

// file: sim/oms_selector_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module oms_selector_assertions #(
    parameter int unsigned PRESS_CYCLES = oms_pkg::PRESS_CYCLES,
    parameter int unsigned SERVICE_CYCLES = oms_pkg::SERVICE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic button1_i,
    input wire logic button2_i,
    input wire logic key_present_i,
    input wire logic [1:0] key_class_i,
    input wire logic [3:0] config_switch_i,
    input wire oms_pkg::oms_mode_out_t mode_o,
    input wire logic [4:0] auth_led_o,
    input wire logic [3:0] status_signal_outputs_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    int unsigned b1_run;
    int unsigned b2_run;

    // held cycles of each button
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            b1_run <= 0;
            b2_run <= 0;
        end else begin
            b1_run <= button1_i ? b1_run + 1 : 0;
            b2_run <= button2_i ? b2_run + 1 : 0;
        end
    end

    onehot_mode_a: assert property ($onehot0(mode_o))
        else $error("mode outputs not one-hot");
    idle_bits_a:
        assert property (mode_o[3:2] == 2'h0 && auth_led_o[3:2] == 2'h0)
        else $error("unused output or indicator high");
    second_sel_a:
        assert property ($rose(mode_o.second_mode_output)
            && $past(mode_o) != 5'h00
            |-> $past(b2_run) >= PRESS_CYCLES && key_class_i[1])
        else $error("second mode without valid press");
    service_sel_a:
        assert property ($rose(mode_o.service_mode_output)
            && $past(mode_o) != 5'h00
            |-> $past(b1_run) >= SERVICE_CYCLES && key_class_i == 2'h3)
        else $error("service mode without long press");
    multi_press_a:
        assert property ($rose(button1_i && button2_i) && key_present_i
            |-> ##[1:4] status_signal_outputs_o == oms_pkg::ST_MULTI_PRESS)
        else $error("multiple press not reported");
    fallback_a:
        assert property ($fell(key_present_i) && mode_o != 5'h00
            && config_switch_i[1:0] == oms_pkg::BEH_FALLBACK
            |-> ##[1:4] mode_o == 5'h01)
        else $error("key removal did not force first mode");
    cfg_error_a:
        assert property ($changed(config_switch_i) && mode_o != 5'h00
            |-> ##[1:4] status_signal_outputs_o == oms_pkg::ST_DEV_ERROR
            && mode_o == 5'h00)
        else $error("switch change not a device error");
    auth_led_a:
        assert property (key_present_i [*6] ##0 mode_o != 5'h00
            |-> auth_led_o == {key_class_i == 2'h3, 2'h0, key_class_i[1],
            key_class_i != 2'h0})
        else $error("indicators do not match key class");
endmodule : oms_selector_assertions
`default_nettype wire

// file: sim/test_operating_mode_selector.sv
`timescale 1ns/10ps
`default_nettype none
module test_operating_mode_selector;
    localparam int PRESS = 20;
    localparam int SVC = 60;
    localparam logic [31:0] KID = 32'hC3A5_5A3C;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic b1 = 1'b0;
    logic b2 = 1'b0;
    logic key = 1'b0;
    logic [1:0] cls = 2'h0;
    logic [3:0] cfg = 4'hA;
    logic [1:0] stored = 2'h0;
    logic req = 1'b0;
    logic slow = 1'b0;
    oms_pkg::oms_apb_req_t apb_q = '0;
    oms_pkg::oms_apb_rsp_t apb_r;
    oms_pkg::oms_mode_out_t mode;
    logic [1:0] bl;
    logic [4:0] auth;
    logic [3:0] st;
    logic [2:0] id_out;
    logic [1:0] id_in;
    logic sh_o;
    logic sh_oe;
    wire logic sh_w;
    logic [31:0] word;
    logic [5:0] bits;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int n_compared = 0;

    assign sh_w = sh_oe ? sh_o : 1'b0;
    always #20 clk_i = ~clk_i;

    oms_selector #(
        .PRESS_CYCLES(PRESS),
        .SERVICE_CYCLES(SVC),
        .FLASH_CYCLES(8)
    ) dut_u (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .button1_i(b1),
        .button2_i(b2),
        .key_present_i(key),
        .key_class_i(cls),
        .key_id_i(KID),
        .config_switch_i(cfg),
        .stored_mode_i(stored),
        .store_we_o(),
        .store_mode_o(),
        .mode_o(mode),
        .backlight_o(bl),
        .auth_led_o(auth),
        .status_signal_outputs_o(st),
        .key_ident_outputs_o(id_out),
        .key_ident_inputs_i(id_in),
        .ident_shared_i(sh_w),
        .ident_shared_o(sh_o),
        .ident_shared_oe_o(sh_oe),
        .apb_i(apb_q),
        .apb_o(apb_r)
    );

    oms_ctrl_model ctl_u (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .req_i(req),
        .slow_i(slow),
        .ident_i(id_out),
        .ident_o(id_in),
        .word_o(word),
        .bits_o(bits)
    );

    task results;
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    task boot(input logic [3:0] c, input logic [1:0] s);
        rst_b_i <= 1'b0;
        cfg <= c;
        stored <= s;
        tick(12);
        rst_b_i <= 1'b1;
        tick(4);
    endtask : boot

    task insert(input logic [1:0] c);
        key <= 1'b0;
        tick(8);
        cls <= c;
        key <= 1'b1;
        tick(8);
    endtask : insert

    task press(input logic p1, input logic p2, input int n);
        b1 <= p1;
        b2 <= p2;
        tick(n);
        b1 <= 1'b0;
        b2 <= 1'b0;
        tick(6);
    endtask : press

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        apb_q.psel <= 1'b1;
        apb_q.pwrite <= wr;
        apb_q.paddr <= a;
        apb_q.pwdata <= d;
        tick(1);
        apb_q.penable <= 1'b1;
        for (i = 0; i < 9; i++) begin
            tick(1);
            if (apb_r.pready === 1'b1) break;
        end
        rd = apb_r.prdata;
        er = apb_r.pslverr;
        apb_q.psel <= 1'b0;
        apb_q.penable <= 1'b0;
        tick(1);
        if (i == 9) begin
            err_count++;
            results();
        end
    endtask : apb

    task sc_start;
        chk(mode, 5'h01);
        chk(bl, 2'h1);
        press(1'b0, 1'b1, 30);
        chk(mode, 5'h01);
    endtask : sc_start

    task sc_class;
        insert(oms_pkg::KEY_CLASS_01);
        chk(st, oms_pkg::ST_KEY_IN);
        chk(auth, 5'h01);
        press(1'b0, 1'b1, 30);
        chk(mode, 5'h01);
        chk(st, oms_pkg::ST_NO_AUTH);
        insert(oms_pkg::KEY_CLASS_02);
        chk(auth, 5'h03);
        press(1'b0, 1'b1, PRESS / 2);
        chk(mode, 5'h01);
        press(1'b0, 1'b1, 30);
        chk(mode, 5'h02);
        chk(bl, 2'h2);
        chk(st, oms_pkg::ST_SELECTED);
    endtask : sc_class

    task sc_buttons;
        press(1'b1, 1'b1, 30);
        chk(st, oms_pkg::ST_MULTI_PRESS);
        chk(mode, 5'h02);
        press(1'b1, 1'b0, SVC + 10);
        chk(mode, 5'h02);
        press(1'b1, 1'b0, 30);
        chk(mode, 5'h01);
    endtask : sc_buttons

    task sc_service;
        insert(oms_pkg::KEY_CLASS_SERVICE);
        chk(auth, 5'h13);
        press(1'b1, 1'b0, SVC + 10);
        chk(mode, 5'h10);
        key <= 1'b0;
        tick(6);
        chk(mode, 5'h01);
        chk(bl, 2'h1);
        chk(st, oms_pkg::ST_KEY_OUT);
    endtask : sc_service

    task sc_ident;
        int i;
        slow <= 1'b1;
        insert(oms_pkg::KEY_CLASS_SERVICE);
        req <= 1'b1;
        for (i = 0; i < 800 && bits !== 6'h20; i++) begin
            tick(1);
        end
        if (i == 800) begin
            err_count++;
            results();
        end
        tick(2);
        chk(word, KID);
        req <= 1'b0;
        apb(1'b0, oms_pkg::ADDR_KEY_ID, 32'h0);
        chk(rd, KID);
    endtask : sc_ident

    task sc_regs;
        apb(1'b0, 8'h0C, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        cfg <= 4'hC;
        tick(6);
        chk(st, oms_pkg::ST_DEV_ERROR);
        chk(mode, 5'h00);
        cfg <= 4'hA;
        apb(1'b1, oms_pkg::ADDR_CONTROL, 32'h3);
        tick(6);
        chk(mode, 5'h01);
        press(1'b0, 1'b1, 30);
        chk(mode, 5'h01);
    endtask : sc_regs

    task sc_retain;
        boot(4'h7, 2'h1);
        chk(mode, 5'h02);
        chk({sh_oe, sh_o}, 32'h3);
        boot(4'h2, 2'h1);
        chk(mode, 5'h01);
    endtask : sc_retain

    initial begin
        boot(4'hA, 2'h0);
        sc_start();
        sc_class();
        sc_buttons();
        sc_service();
        sc_ident();
        sc_regs();
        sc_retain();
        results();
    end
endmodule : test_operating_mode_selector

bind oms_selector oms_selector_assertions #(
    .PRESS_CYCLES(PRESS_CYCLES),
    .SERVICE_CYCLES(SERVICE_CYCLES)
) chk_u (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .button1_i(button1_i),
    .button2_i(button2_i),
    .key_present_i(key_present_i),
    .key_class_i(key_class_i),
    .config_switch_i(config_switch_i),
    .mode_o(mode_o),
    .auth_led_o(auth_led_o),
    .status_signal_outputs_o(status_signal_outputs_o)
);
`default_nettype wire

// file: verilog/oms_pkg.sv
package oms_pkg;

    // clock and timing
    localparam int CLK_KHZ = 25000;
    localparam int PRESS_MS = 500;
    localparam int SERVICE_MS = 3000;
    localparam int FLASH_MS = 250;
    localparam int ID_BIT_US = 100;
    localparam int PRESS_CYCLES = PRESS_MS * CLK_KHZ;
    localparam int SERVICE_CYCLES = SERVICE_MS * CLK_KHZ;
    localparam int FLASH_CYCLES = FLASH_MS * CLK_KHZ;
    localparam int ID_BIT_CYCLES = (ID_BIT_US * CLK_KHZ) / 1000;

    // counter widths
    localparam int HOLD_W = 27;
    localparam int FLASH_W = 23;
    localparam int ID_TMR_W = 12;
    localparam int ID_BITS = 32;
    localparam int ID_CNT_W = 6;
    localparam logic [ID_CNT_W-1:0] ID_CNT_LOAD = 6'h20;
    localparam logic [ID_CNT_W-1:0] ID_CNT_LAST = 6'h01;

    // apb register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_KEY_ID = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h08;
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_LOCK_RESET = 1'h0;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_ERR_BIT = 5;
    localparam int STAT_KEY_BIT = 6;
    localparam int STAT_LOCK_BIT = 7;
    localparam int STAT_CLASS_LSB = 8;
    localparam int STAT_CFG_LSB = 12;
    localparam int STAT_CODE_LSB = 16;

    // key classes
    localparam logic [1:0] KEY_CLASS_01 = 2'h1;
    localparam logic [1:0] KEY_CLASS_02 = 2'h2;
    localparam logic [1:0] KEY_CLASS_SERVICE = 2'h3;

    // configuration switch fields
    localparam int CFG_BEH_LSB = 0;
    localparam int CFG_ADV_BIT = 2;
    localparam int CFG_HS_BIT = 3;
    localparam logic [1:0] BEH_SVC_FALLBACK = 2'h0;
    localparam logic [1:0] BEH_HOLD = 2'h1;
    localparam logic [1:0] BEH_FALLBACK = 2'h2;
    localparam logic [1:0] BEH_STORE = 2'h3;

    // status codes
    localparam logic [3:0] ST_IDLE = 4'h0;
    localparam logic [3:0] ST_KEY_IN = 4'h1;
    localparam logic [3:0] ST_KEY_OUT = 4'h2;
    localparam logic [3:0] ST_SELECTED = 4'h3;
    localparam logic [3:0] ST_MULTI_PRESS = 4'h4;
    localparam logic [3:0] ST_NO_AUTH = 4'h5;
    localparam logic [3:0] ST_DEV_ERROR = 4'h6;

    typedef enum logic [1:0] {
        PH_INIT = 2'b00,
        PH_RUN = 2'b01,
        PH_ERROR = 2'b10
    } oms_phase_t;

    typedef enum logic [1:0] {
        MODE_FIRST = 2'b00,
        MODE_SECOND = 2'b01,
        MODE_SERVICE = 2'b10
    } oms_mode_t;

    typedef struct packed {
        logic service_mode_output;
        logic unused_mode_output_b;
        logic unused_mode_output_a;
        logic second_mode_output;
        logic first_mode_output;
    } oms_mode_out_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } oms_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } oms_apb_rsp_t;

    typedef struct packed {
        logic [HOLD_W-1:0] cnt;
        logic min;
        logic svc;
    } oms_timer_t;

    typedef struct packed {
        oms_phase_t phase;
        oms_mode_t mode;
        logic [3:0] cfg;
        logic key_seen;
        logic b1_prev;
        logic blocked;
        logic done;
        logic [3:0] status;
        logic store_we;
        logic lock;
        logic [31:0] prdata;
        logic pslverr;
        oms_mode_out_t outs;
        logic [1:0] backlight;
        logic [4:0] auth_led;
        logic [FLASH_W-1:0] flash_cnt;
        logic flash;
        logic id_active;
        logic [ID_BITS-1:0] id_shift;
        logic [ID_CNT_W-1:0] id_cnt;
        logic [ID_TMR_W-1:0] id_tmr;
        logic id_strobe;
        logic req_prev;
        logic ack_prev;
        logic shared_out;
    } oms_state_t;

endpackage : oms_pkg

// file: verilog/oms_press_timer.sv
`timescale 1ns/10ps
`default_nettype none
module oms_press_timer #(
    parameter logic [oms_pkg::HOLD_W-1:0] MIN_COUNT = 27'h0BEBC20,
    parameter logic [oms_pkg::HOLD_W-1:0] SVC_COUNT = 27'h47868C0
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    output logic min_o,
    output logic svc_o
);

    oms_pkg::oms_timer_t s;
    oms_pkg::oms_timer_t n;

    // counts held cycles, saturating at the service threshold
    always_comb begin
        n = s;
        if (!run_i) begin
            n.cnt = '0;
        end else if (s.cnt < SVC_COUNT) begin
            n.cnt = s.cnt + 27'h0000001;
        end
        n.min = run_i && (n.cnt >= MIN_COUNT);
        n.svc = run_i && (n.cnt >= SVC_COUNT);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign min_o = s.min;
    assign svc_o = s.svc;

endmodule : oms_press_timer
`default_nettype wire

// file: verilog/oms_selector.sv
// Contract
// - at most one mode output high
// - accepted press switches to its mode output
// - service only after long hold of button one
// - press counts only after minimum hold time
// - multiple buttons pressed is an operator error
// - selection needs key in contact
// - key class decodes permitted modes
// - without retention restart enters first mode
// - with retention restart restores last mode
// - backlight shows selected mode
// - indicators 1, 2, 5 show rights
// - button one first/service, button two second
// - outputs one, two, five monitored; three, four idle
// - four status outputs report actions and errors
// - ident port three out, two in, shared line
// - ident download in one of three modes
// - key id and class read on contact
// - fallback removal forces first mode
// - invalid or changed switch gives device error
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module oms_selector #(
    parameter int unsigned PRESS_CYCLES = oms_pkg::PRESS_CYCLES,
    parameter int unsigned SERVICE_CYCLES = oms_pkg::SERVICE_CYCLES,
    parameter int unsigned FLASH_CYCLES = oms_pkg::FLASH_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic button1_i,
    input wire logic button2_i,
    input wire logic key_present_i,
    input wire logic [1:0] key_class_i,
    input wire logic [31:0] key_id_i,
    input wire logic [3:0] config_switch_i,
    input wire logic [1:0] stored_mode_i,
    output logic store_we_o,
    output logic [1:0] store_mode_o,
    output oms_pkg::oms_mode_out_t mode_o,
    output logic [1:0] backlight_o,
    output logic [4:0] auth_led_o,
    output logic [3:0] status_signal_outputs_o,
    output logic [2:0] key_ident_outputs_o,
    input wire logic [1:0] key_ident_inputs_i,
    input wire logic ident_shared_i,
    output logic ident_shared_o,
    output logic ident_shared_oe_o,
    input wire oms_pkg::oms_apb_req_t apb_i,
    output oms_pkg::oms_apb_rsp_t apb_o
);

    localparam logic [oms_pkg::HOLD_W-1:0] MIN_CNT =
        PRESS_CYCLES[oms_pkg::HOLD_W-1:0];
    localparam logic [oms_pkg::HOLD_W-1:0] SVC_CNT =
        SERVICE_CYCLES[oms_pkg::HOLD_W-1:0];
    localparam logic [oms_pkg::FLASH_W-1:0] FLASH_LAST =
        oms_pkg::FLASH_W'(FLASH_CYCLES - 1);
    localparam logic [oms_pkg::ID_TMR_W-1:0] ID_TMR_LAST =
        oms_pkg::ID_TMR_W'(oms_pkg::ID_BIT_CYCLES - 1);

    oms_pkg::oms_state_t s;
    oms_pkg::oms_state_t n;
    logic min_hit;
    logic svc_hit;
    logic timer_run;
    logic single;
    logic both;
    logic b1_release;
    logic key_in;
    logic key_out;
    logic [2:0] auth;
    logic cfg_ok;
    logic advanced;
    logic handshake;
    logic id_start;
    logic id_step;
    logic apb_setup;
    logic apb_write;
    logic [31:0] status_word;

    assign single = button1_i ^ button2_i;
    assign both = button1_i & button2_i;
    assign timer_run = single && !s.blocked && !s.done;
    assign b1_release = s.b1_prev && !button1_i;
    assign key_in = key_present_i && !s.key_seen;
    assign key_out = !key_present_i && s.key_seen;
    assign cfg_ok = !(config_switch_i[oms_pkg::CFG_ADV_BIT] &&
                      config_switch_i[oms_pkg::CFG_HS_BIT]);
    assign advanced = s.cfg[oms_pkg::CFG_ADV_BIT];
    assign handshake = s.cfg[oms_pkg::CFG_HS_BIT];
    assign apb_setup = apb_i.psel && !apb_i.penable;
    assign apb_write = apb_i.psel && apb_i.penable && apb_i.pwrite;

    // rights per key class: bit0 first, bit1 second, bit2 service
    always_comb begin
        auth = 3'h0;
        if (key_present_i) begin
            unique case (key_class_i)
                oms_pkg::KEY_CLASS_01: auth = 3'h1;
                oms_pkg::KEY_CLASS_02: auth = 3'h3;
                oms_pkg::KEY_CLASS_SERVICE: auth = 3'h7;
                default: auth = 3'h0;
            endcase
        end
    end

    always_comb begin
        status_word = 32'h00000000;
        status_word[oms_pkg::STAT_MODE_LSB +: 5] = s.outs;
        status_word[oms_pkg::STAT_ERR_BIT] = (s.phase == oms_pkg::PH_ERROR);
        status_word[oms_pkg::STAT_KEY_BIT] = s.key_seen;
        status_word[oms_pkg::STAT_LOCK_BIT] = s.lock;
        status_word[oms_pkg::STAT_CLASS_LSB +: 2] = key_class_i;
        status_word[oms_pkg::STAT_CFG_LSB +: 4] = s.cfg;
        status_word[oms_pkg::STAT_CODE_LSB +: 4] = s.status;
    end

    // download start and step conditions per mode
    always_comb begin
        if (!advanced && !handshake) begin
            id_start = key_in;
            id_step = (s.id_tmr == ID_TMR_LAST);
        end else begin
            id_start = key_present_i && key_ident_inputs_i[0] &&
                       !s.req_prev;
            id_step = key_ident_inputs_i[1] && !s.ack_prev;
        end
    end

    always_comb begin
        n = s;
        n.b1_prev = button1_i;
        n.key_seen = key_present_i;
        n.req_prev = key_ident_inputs_i[0];
        n.ack_prev = key_ident_inputs_i[1];
        // apb slave, zero wait state
        if (apb_setup) begin
            n.pslverr = 1'b0;
            unique case (apb_i.paddr)
                oms_pkg::ADDR_STATUS: n.prdata = status_word;
                oms_pkg::ADDR_KEY_ID: n.prdata =
                    key_present_i ? key_id_i : 32'h00000000;
                oms_pkg::ADDR_CONTROL: n.prdata = {31'h00000000, s.lock};
                default: begin
                    n.prdata = 32'h00000000;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (apb_write && apb_i.paddr == oms_pkg::ADDR_CONTROL) begin
            n.lock = apb_i.pwdata[oms_pkg::CTRL_LOCK_BIT];
            if (apb_i.pwdata[oms_pkg::CTRL_CLEAR_BIT] &&
                s.phase == oms_pkg::PH_ERROR) begin
                n.phase = oms_pkg::PH_INIT;
            end
        end
        // button bookkeeping
        if (!button1_i && !button2_i) begin
            n.blocked = 1'b0;
            n.done = 1'b0;
        end else if (both && !s.blocked) begin
            n.blocked = 1'b1;
            n.status = oms_pkg::ST_MULTI_PRESS;
        end
        unique case (s.phase)
            oms_pkg::PH_INIT: begin
                n.cfg = config_switch_i;
                n.status = oms_pkg::ST_IDLE;
                if (!cfg_ok) begin
                    n.phase = oms_pkg::PH_ERROR;
                    n.status = oms_pkg::ST_DEV_ERROR;
                end else begin
                    n.phase = oms_pkg::PH_RUN;
                    n.mode = oms_pkg::MODE_FIRST;
                    if (config_switch_i[1:0] == oms_pkg::BEH_STORE &&
                        stored_mode_i != 2'h3) begin
                        n.mode = oms_pkg::oms_mode_t'(stored_mode_i);
                    end
                end
            end
            oms_pkg::PH_RUN: begin
                if (config_switch_i != s.cfg) begin
                    n.phase = oms_pkg::PH_ERROR;
                    n.status = oms_pkg::ST_DEV_ERROR;
                end else begin
                    if (key_in) begin
                        n.status = oms_pkg::ST_KEY_IN;
                    end
                    if (key_out) begin
                        n.status = oms_pkg::ST_KEY_OUT;
                        if (s.cfg[1:0] == oms_pkg::BEH_FALLBACK ||
                            (s.cfg[1:0] == oms_pkg::BEH_SVC_FALLBACK &&
                             s.mode == oms_pkg::MODE_SERVICE)) begin
                            n.mode = oms_pkg::MODE_FIRST;
                        end
                    end
                    // long hold on button one asks for service
                    if (button1_i && svc_hit && !s.done && !s.blocked) begin
                        n.done = 1'b1;
                        if (key_present_i && !s.lock) begin
                            if (auth[2]) begin
                                n.mode = oms_pkg::MODE_SERVICE;
                                n.status = oms_pkg::ST_SELECTED;
                            end else begin
                                n.status = oms_pkg::ST_NO_AUTH;
                            end
                        end
                    end else if (b1_release && min_hit && !s.done &&
                                 !s.blocked) begin
                        if (key_present_i && !s.lock) begin
                            if (auth[0]) begin
                                n.mode = oms_pkg::MODE_FIRST;
                                n.status = oms_pkg::ST_SELECTED;
                            end else begin
                                n.status = oms_pkg::ST_NO_AUTH;
                            end
                        end
                    end else if (button2_i && !button1_i && min_hit &&
                                 !s.done && !s.blocked) begin
                        n.done = 1'b1;
                        if (key_present_i && !s.lock) begin
                            if (auth[1]) begin
                                n.mode = oms_pkg::MODE_SECOND;
                                n.status = oms_pkg::ST_SELECTED;
                            end else begin
                                n.status = oms_pkg::ST_NO_AUTH;
                            end
                        end
                    end
                end
            end
            oms_pkg::PH_ERROR: begin
                n.status = oms_pkg::ST_DEV_ERROR;
            end
            default: begin
                n.phase = oms_pkg::PH_ERROR;
            end
        endcase
        // retention store pulse on every change while running
        n.store_we = (n.phase == oms_pkg::PH_RUN) &&
                     (s.phase == oms_pkg::PH_RUN) && (n.mode != s.mode);
        // one-hot outputs, all low outside normal running
        n.outs = '0;
        n.backlight = 2'h0;
        if (n.phase == oms_pkg::PH_RUN) begin
            unique case (n.mode)
                oms_pkg::MODE_FIRST: begin
                    n.outs.first_mode_output = 1'b1;
                    n.backlight = 2'h1;
                end
                oms_pkg::MODE_SECOND: begin
                    n.outs.second_mode_output = 1'b1;
                    n.backlight = 2'h2;
                end
                oms_pkg::MODE_SERVICE: begin
                    n.outs.service_mode_output = 1'b1;
                    n.backlight = {s.flash, s.flash};
                end
                default: begin
                    n.outs = '0;
                end
            endcase
        end
        if (s.flash_cnt == FLASH_LAST) begin
            n.flash_cnt = '0;
            n.flash = !s.flash;
        end else begin
            n.flash_cnt = s.flash_cnt + 23'h000001;
        end
        n.auth_led = {auth[2], 2'h0, auth[1], auth[0]};
        // key ident download
        if (!advanced) begin
            n.shared_out = 1'b0;
        end else begin
            n.shared_out = key_present_i && (auth != 3'h0);
        end
        if (!key_present_i || (!advanced && ident_shared_i)) begin
            n.id_active = 1'b0;
        end else if (id_start && s.phase == oms_pkg::PH_RUN) begin
            n.id_active = 1'b1;
            n.id_shift = key_id_i;
            n.id_cnt = oms_pkg::ID_CNT_LOAD;
            n.id_tmr = '0;
            n.id_strobe = 1'b0;
        end else if (s.id_active) begin
            n.id_tmr = id_step ? '0 : s.id_tmr + 12'h001;
            if (id_step) begin
                n.id_shift = {s.id_shift[oms_pkg::ID_BITS-2:0], 1'b0};
                n.id_cnt = s.id_cnt - 6'h01;
                n.id_strobe = !s.id_strobe;
                if (s.id_cnt == oms_pkg::ID_CNT_LAST) begin
                    n.id_active = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
            s.phase <= oms_pkg::PH_INIT;
            s.lock <= oms_pkg::CTRL_LOCK_RESET;
        end else begin
            s <= n;
        end
    end

    oms_press_timer #(
        .MIN_COUNT(MIN_CNT),
        .SVC_COUNT(SVC_CNT)
    ) u_timer (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .run_i(timer_run),
        .min_o(min_hit),
        .svc_o(svc_hit)
    );

    assign store_we_o = s.store_we;
    assign store_mode_o = s.mode;
    assign mode_o = s.outs;
    assign backlight_o = s.backlight;
    assign auth_led_o = s.auth_led;
    assign status_signal_outputs_o = s.status;
    assign key_ident_outputs_o = {s.id_active, s.id_strobe,
                                  s.id_active & s.id_shift[31]};
    assign ident_shared_o = s.shared_out;
    assign ident_shared_oe_o = advanced && (s.phase != oms_pkg::PH_INIT);
    assign apb_o.pready = apb_i.psel && apb_i.penable;
    assign apb_o.pslverr = apb_i.psel && apb_i.penable && s.pslverr;
    assign apb_o.prdata = s.prdata;

endmodule : oms_selector
`default_nettype wire
